// ==== rtl/buck_prot_regs.svh ====
`ifndef BUCK_PROT_REGS_SVH
`define BUCK_PROT_REGS_SVH

// Read command codes, which double as register offsets
`define CMD_LOAD_CURRENT     8'h8c
`define CMD_CURRENT_CEILING  8'hdd

// Report registers
`define REPORT_W             16
`define REPORT_RESET         16'h0000
`define REPORT_SAT           16'h00ff
`define REPORT_UNMAPPED      16'h0000

// Clock
`define CLK_PERIOD_NS        50

// Overvoltage filter, 1 us, longer than which the excursion trips
`define OV_FILT_NS           1000
`define OV_FILT_CYC          (`OV_FILT_NS / `CLK_PERIOD_NS)

// Undervoltage filter, 5 us
`define UV_FILT_NS           5000
`define UV_FILT_CYC          (`UV_FILT_NS / `CLK_PERIOD_NS)

// Latch-off ramp-down slew, 0.5 mV/us expressed in uV/us; one mV step per period
`define RAMP_SLEW_UV_PER_US  500
`define RAMP_STEP_NS         (1000000 / `RAMP_SLEW_UV_PER_US)
`define RAMP_STEP_CYC        (`RAMP_STEP_NS / `CLK_PERIOD_NS)

// Voltages in mV
`define OV_SOFT_START_MV     17'd2100
`define OV_HYST_MV           17'd25

// Protection option strap codes, in order of strap resistance
`define STRAP_FLOAT          3'h0
`define STRAP_33K            3'h1
`define STRAP_20K            3'h2
`define STRAP_13K            3'h3
`define STRAP_8K2            3'h4
`define STRAP_5K1            3'h5
`define STRAP_2K7            3'h6
`define STRAP_SHORT          3'h7

`endif

// ==== rtl/buck_prot_pkg.sv ====
package buck_prot_pkg;

	typedef enum logic [8:0] {
		ST_OFF        = 9'b000000001,
		ST_SOFT_START = 9'b000000010,
		ST_GOOD_DELAY = 9'b000000100,
		ST_RUN        = 9'b000001000,
		ST_OV_RECOVER = 9'b000010000,
		ST_OV_RAMP    = 9'b000100000,
		ST_OV_HOLD    = 9'b001000000,
		ST_LATCH_OFF  = 9'b010000000,
		ST_HICCUP     = 9'b100000000
	} state_t;

endpackage : buck_prot_pkg

// ==== rtl/code_sat.sv ====
`timescale 1ns/100ps
`include "buck_prot_regs.svh"

// Converter sample to 1 A per LSB report code, saturating at full scale
module code_sat #(
	parameter int IN_W  = 10,
	parameter int SHIFT = 2
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_load,
	input  wire logic [IN_W-1:0]      i_sample,
	output logic      [`REPORT_W-1:0] o_code
);

	wire logic [IN_W-1:0] scaled   = i_sample >> SHIFT;
	wire logic            over     = (scaled > IN_W'(`REPORT_SAT));
	wire logic [`REPORT_W-1:0] next_code = over ? `REPORT_SAT :
		{{(`REPORT_W-8){1'b0}}, scaled[7:0]};

	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			o_code <= `REPORT_RESET;
		else if (i_load)
			o_code <= next_code;
	end

endmodule : code_sat

// ==== rtl/buck_fault_protection_telemetry.sv ====
`timescale 1ns/100ps
`include "buck_prot_regs.svh"

// Overview of operation
// - Six phase outputs: high, low or floating.
// - Off, hiccup and latch-off modes float phases fully.
// - Sample ceiling strap once at enable, readable.
// - Ceiling code 1 A/LSB, saturates at 255.
// - Load current code 1 A/LSB, max 255.
// - Monitor 2 V input gives full-scale code.
// - Strap selects recoverable or latch-off overvoltage.
// - Over threshold beyond 1 us trips, drops good.
// - Recoverable overvoltage drives every phase low.
// - Recover when output more than 25 mV below threshold.
// - Recoverable soft start uses 2.1 V until good or a trip.
// - Latch-off: highs off, reference ramps -0.5 mV/us.
// - Ramp: lows toggle around threshold, 25 mV hysteresis.
// - Ramp at zero: lows on forever.
// - Latch-off soft start 2.1 V until ramp.
// - Latched faults need supply or enable toggle.
// - Overvoltage armed from soft start, not idle.
// - Under threshold beyond 5 us floats, drops good.
// - Undervoltage latches or hiccups, per strap.
// - Undervoltage armed after good delay only.
// - Strap decodes enable, overvoltage and fault options.
module buck_fault_protection_telemetry #(
	parameter int          PHASES         = 6,
	parameter int          ADC_W          = 10,
	parameter int          ADC_SHIFT      = 2,
	parameter logic [16:0] OV_MARGIN_MV   = 17'd200,
	parameter logic [16:0] UV_MARGIN_MV   = 17'd300,
	parameter int          GOOD_DELAY_CYC = 20000,
	parameter int          HICCUP_CYC     = 400000
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_enable,
	input  wire logic              i_supply_ok,
	input  wire logic [2:0]        i_strap_code,
	input  wire logic [ADC_W-1:0]  i_ceiling_sample,
	input  wire logic [ADC_W-1:0]  i_monitor_sample,
	input  wire logic              i_monitor_valid,
	input  wire logic [15:0]       i_sense_mv,
	input  wire logic [15:0]       i_ref_mv,
	input  wire logic              i_soft_start_done,
	input  wire logic              i_other_fault,
	input  wire logic [PHASES-1:0] i_pwm_req,
	input  wire logic              i_cmd_valid,
	input  wire logic [7:0]        i_cmd_code,
	output logic      [PHASES-1:0] o_phase_hi_en,
	output logic      [PHASES-1:0] o_phase_lo_en,
	output logic                   o_output_good,
	output logic                   o_soft_start_run,
	output logic                   o_overvoltage_fault,
	output logic                   o_undervoltage_fault,
	output logic                   o_ramp_active,
	output logic      [15:0]       o_ramp_mv,
	output logic      [15:0]       o_rd_data,
	output logic                   o_rd_valid
);

	localparam logic [7:0]  OV_CYC   = 8'(`OV_FILT_CYC);
	localparam logic [7:0]  UV_CYC   = 8'(`UV_FILT_CYC);
	localparam logic [5:0]  STEP_CYC = 6'(`RAMP_STEP_CYC - 1);
	localparam logic [19:0] GOOD_LD  = 20'(GOOD_DELAY_CYC);
	localparam logic [19:0] HICCUP_LD = 20'(HICCUP_CYC);

	// Pin synchronisers
	logic en_meta;
	logic en_sync;
	logic sup_meta;
	logic sup_sync;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			en_meta  <= 1'b0;
			en_sync  <= 1'b0;
			sup_meta <= 1'b0;
			sup_sync <= 1'b0;
		end else begin
			en_meta  <= i_enable;
			en_sync  <= en_meta;
			sup_meta <= i_supply_ok;
			sup_sync <= sup_meta;
		end
	end

	wire logic running = en_sync & sup_sync;

	buck_prot_pkg::state_t state;
	buck_prot_pkg::state_t next_state;

	// Stored mode code
	logic prot_en;
	logic ovp_latch_mode;
	logic fault_latch_mode;

	wire logic strap_prot_en = (i_strap_code <= `STRAP_13K);
	wire logic strap_ovp_latch = (i_strap_code == `STRAP_20K) ||
		(i_strap_code == `STRAP_13K);
	wire logic strap_fault_latch = (i_strap_code == `STRAP_33K) ||
		(i_strap_code == `STRAP_13K) || (i_strap_code == `STRAP_8K2) ||
		(i_strap_code == `STRAP_5K1);

	wire logic start_up = (state == buck_prot_pkg::ST_OFF) && running;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			prot_en          <= 1'b0;
			ovp_latch_mode   <= 1'b0;
			fault_latch_mode <= 1'b0;
		end else if (start_up) begin
			prot_en          <= strap_prot_en;
			ovp_latch_mode   <= strap_ovp_latch;
			fault_latch_mode <= strap_fault_latch;
		end
	end

	// Threshold arithmetic, one bit wider than the sense value
	logic [15:0] ramp_mv;
	logic [5:0]  ramp_div;
	logic        ovp_tripped;
	logic        good_seen;
	logic        lo_toggle;
	logic [7:0]  ov_cnt;
	logic [7:0]  uv_cnt;
	logic [19:0] timer;

	wire logic in_ss  = (state == buck_prot_pkg::ST_SOFT_START);
	wire logic in_gd  = (state == buck_prot_pkg::ST_GOOD_DELAY);
	wire logic in_run = (state == buck_prot_pkg::ST_RUN);
	wire logic in_rec = (state == buck_prot_pkg::ST_OV_RECOVER);
	wire logic in_ramp = (state == buck_prot_pkg::ST_OV_RAMP);

	wire logic [16:0] sense17 = {1'b0, i_sense_mv};
	wire logic [16:0] ref17   = {1'b0, in_ramp ? ramp_mv : i_ref_mv};
	wire logic [16:0] ov_dyn  = ref17 + OV_MARGIN_MV;
	// Fixed level only in soft start and good delay, and only before any overvoltage trip or ramp
	wire logic use_fixed = (in_ss || in_gd) && !ovp_tripped;
	wire logic [16:0] ov_thr = use_fixed ? `OV_SOFT_START_MV : ov_dyn;
	wire logic over = sense17 > ov_thr;
	wire logic ov_clear = (sense17 + `OV_HYST_MV) < ov_thr;
	wire logic under = (sense17 + UV_MARGIN_MV) < {1'b0, i_ref_mv};

	wire logic ov_armed = prot_en && (in_ss || in_gd || in_run);
	wire logic uv_armed = prot_en && in_run;
	wire logic ov_trip = ov_armed && over && (ov_cnt == OV_CYC);
	wire logic uv_trip = uv_armed && under && (uv_cnt == UV_CYC);
	wire logic other_trip = i_other_fault && (in_ss || in_gd || in_run);

	wire buck_prot_pkg::state_t ov_dest = ovp_latch_mode ?
		buck_prot_pkg::ST_OV_RAMP : buck_prot_pkg::ST_OV_RECOVER;
	wire buck_prot_pkg::state_t fault_dest = fault_latch_mode ?
		buck_prot_pkg::ST_LATCH_OFF : buck_prot_pkg::ST_HICCUP;

	always_comb begin
		next_state = state;
		if (!running) begin
			next_state = buck_prot_pkg::ST_OFF;
		end else begin
			unique case (state)
				buck_prot_pkg::ST_OFF:
					next_state = buck_prot_pkg::ST_SOFT_START;
				buck_prot_pkg::ST_SOFT_START: begin
					if (ov_trip)
						next_state = ov_dest;
					else if (other_trip)
						next_state = fault_dest;
					else if (i_soft_start_done)
						next_state = buck_prot_pkg::ST_GOOD_DELAY;
				end
				buck_prot_pkg::ST_GOOD_DELAY: begin
					if (ov_trip)
						next_state = ov_dest;
					else if (other_trip)
						next_state = fault_dest;
					else if (timer == 20'h00000)
						next_state = buck_prot_pkg::ST_RUN;
				end
				buck_prot_pkg::ST_RUN: begin
					if (ov_trip)
						next_state = ov_dest;
					else if (uv_trip || other_trip)
						next_state = fault_dest;
				end
				buck_prot_pkg::ST_OV_RECOVER: begin
					if (ov_clear)
						next_state = good_seen ? buck_prot_pkg::ST_RUN :
							buck_prot_pkg::ST_SOFT_START;
				end
				buck_prot_pkg::ST_OV_RAMP: begin
					if (ramp_mv == 16'h0000)
						next_state = buck_prot_pkg::ST_OV_HOLD;
				end
				buck_prot_pkg::ST_OV_HOLD:
					next_state = buck_prot_pkg::ST_OV_HOLD;
				buck_prot_pkg::ST_LATCH_OFF:
					next_state = buck_prot_pkg::ST_LATCH_OFF;
				buck_prot_pkg::ST_HICCUP: begin
					if (timer == 20'h00000)
						next_state = buck_prot_pkg::ST_SOFT_START;
				end
				default:
					next_state = buck_prot_pkg::ST_OFF;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			state <= buck_prot_pkg::ST_OFF;
		else
			state <= next_state;
	end

	// Filters restart on any gap in the excursion
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !ov_armed || !over)
			ov_cnt <= 8'h00;
		else if (ov_cnt != OV_CYC)
			ov_cnt <= ov_cnt + 8'h01;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !uv_armed || !under)
			uv_cnt <= 8'h00;
		else if (uv_cnt != UV_CYC)
			uv_cnt <= uv_cnt + 8'h01;
	end

	wire logic enter_gd = in_ss && (next_state == buck_prot_pkg::ST_GOOD_DELAY);
	wire logic enter_hic = (state != buck_prot_pkg::ST_HICCUP) &&
		(next_state == buck_prot_pkg::ST_HICCUP);

	// One timer serves the good delay and the hiccup wait; they never overlap
	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			timer <= 20'h00000;
		else if (enter_gd)
			timer <= GOOD_LD;
		else if (enter_hic)
			timer <= HICCUP_LD;
		else if (timer != 20'h00000)
			timer <= timer - 20'h00001;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || state == buck_prot_pkg::ST_OFF) begin
			ovp_tripped <= 1'b0;
			good_seen   <= 1'b0;
		end else begin
			if (ov_trip)
				ovp_tripped <= 1'b1;
			if (in_run)
				good_seen <= 1'b1;
		end
	end

	// Reference ramp-down, one mV per step period
	wire logic ramp_start = ov_trip && ovp_latch_mode;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ramp_mv  <= 16'h0000;
			ramp_div <= 6'h00;
		end else if (ramp_start) begin
			ramp_mv  <= i_ref_mv;
			ramp_div <= STEP_CYC;
		end else if (in_ramp && ramp_mv != 16'h0000) begin
			if (ramp_div == 6'h00) begin
				ramp_mv  <= ramp_mv - 16'h0001;
				ramp_div <= STEP_CYC;
			end else begin
				ramp_div <= ramp_div - 6'h01;
			end
		end
	end

	// Low sides on at the trip, then bang-bang around the falling threshold
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || ramp_start)
			lo_toggle <= 1'b1;
		else if (in_ramp && over)
			lo_toggle <= 1'b1;
		else if (in_ramp && ov_clear)
			lo_toggle <= 1'b0;
	end

	// Phase drive; both enables low leaves a pin floating for the mid level
	logic [PHASES-1:0] next_hi;
	logic [PHASES-1:0] next_lo;

	always_comb begin
		next_hi = '0;
		next_lo = '0;
		unique case (next_state)
			buck_prot_pkg::ST_SOFT_START, buck_prot_pkg::ST_GOOD_DELAY,
			buck_prot_pkg::ST_RUN: begin
				next_hi = i_pwm_req;
				next_lo = ~i_pwm_req;
			end
			buck_prot_pkg::ST_OV_RECOVER:
				next_lo = '1;
			buck_prot_pkg::ST_OV_RAMP:
				next_lo = {PHASES{lo_toggle}};
			buck_prot_pkg::ST_OV_HOLD:
				next_lo = '1;
			default: begin
				next_hi = '0;
				next_lo = '0;
			end
		endcase
	end

	wire logic next_ovp = (next_state == buck_prot_pkg::ST_OV_RECOVER) ||
		(next_state == buck_prot_pkg::ST_OV_RAMP) ||
		(next_state == buck_prot_pkg::ST_OV_HOLD);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_phase_hi_en        <= '0;
			o_phase_lo_en        <= '0;
			o_output_good        <= 1'b0;
			o_soft_start_run     <= 1'b0;
			o_overvoltage_fault  <= 1'b0;
			o_undervoltage_fault <= 1'b0;
			o_ramp_active        <= 1'b0;
			o_ramp_mv            <= 16'h0000;
		end else begin
			o_phase_hi_en       <= next_hi;
			o_phase_lo_en       <= next_lo;
			o_output_good       <= (next_state == buck_prot_pkg::ST_RUN);
			o_soft_start_run    <= (next_state == buck_prot_pkg::ST_SOFT_START);
			o_overvoltage_fault <= next_ovp;
			o_ramp_active       <= (next_state == buck_prot_pkg::ST_OV_RAMP) ||
				(next_state == buck_prot_pkg::ST_OV_HOLD);
			o_ramp_mv           <= ramp_mv;
			// A trip in the cycle that enable or supply drops still marks the fault
			if (uv_trip)
				o_undervoltage_fault <= 1'b1;
			else if (!running)
				o_undervoltage_fault <= 1'b0;
		end
	end

	// Report registers
	logic [`REPORT_W-1:0] ceiling_code;
	logic [`REPORT_W-1:0] load_code;

	code_sat #(
		.IN_W  (ADC_W),
		.SHIFT (ADC_SHIFT)
	) u_ceiling (
		.i_clk    (i_clk),
		.i_rst_n  (i_rst_n),
		.i_load   (start_up),
		.i_sample (i_ceiling_sample),
		.o_code   (ceiling_code)
	);

	code_sat #(
		.IN_W  (ADC_W),
		.SHIFT (ADC_SHIFT)
	) u_load (
		.i_clk    (i_clk),
		.i_rst_n  (i_rst_n),
		.i_load   (i_monitor_valid),
		.i_sample (i_monitor_sample),
		.o_code   (load_code)
	);

	wire logic hit_load    = (i_cmd_code == `CMD_LOAD_CURRENT);
	wire logic hit_ceiling = (i_cmd_code == `CMD_CURRENT_CEILING);
	wire logic [`REPORT_W-1:0] rd_mux = hit_load ? load_code :
		hit_ceiling ? ceiling_code : `REPORT_UNMAPPED;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rd_data  <= `REPORT_RESET;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_cmd_valid;
			if (i_cmd_valid)
				o_rd_data <= rd_mux;
		end
	end

endmodule : buck_fault_protection_telemetry

// ==== tb/phase_receiver_model.sv ====
`timescale 1ns/100ps

// Receiver end of the six phase lines; its divider pulls an undriven pin to mid level
module phase_receiver_model #(
	parameter int PHASES = 6
) (
	input  wire logic [PHASES-1:0] i_hi_en,
	input  wire logic [PHASES-1:0] i_lo_en,
	output logic      [PHASES-1:0] o_mid,
	output logic      [PHASES-1:0] o_level
);
	assign o_mid   = ~i_hi_en & ~i_lo_en;
	assign o_level = i_hi_en & ~i_lo_en;
endmodule : phase_receiver_model

// ==== tb/buck_prot_sva.sv ====
`timescale 1ns/100ps

module buck_prot_sva #(
	parameter int          PHASES       = 6,
	parameter logic [16:0] OV_MARGIN_MV = 17'd200
) (
	input wire logic              i_clk,
	input wire logic              i_rst_n,
	input wire logic              i_enable,
	input wire logic [15:0]       i_sense_mv,
	input wire logic [15:0]       i_ref_mv,
	input wire logic              i_cmd_valid,
	input wire logic [PHASES-1:0] o_phase_hi_en,
	input wire logic [PHASES-1:0] o_phase_lo_en,
	input wire logic              o_output_good,
	input wire logic              o_soft_start_run,
	input wire logic              o_overvoltage_fault,
	input wire logic              o_undervoltage_fault,
	input wire logic              o_ramp_active,
	input wire logic [15:0]       o_ramp_mv,
	input wire logic [15:0]       o_rd_data,
	input wire logic              o_rd_valid
);
	logic [4:0] over_cnt;
	logic [4:0] next_over_cnt;
	wire        over = {1'b0, i_sense_mv} > {1'b0, i_ref_mv} + OV_MARGIN_MV;
	wire        flt  = o_phase_hi_en == '0 && o_phase_lo_en == '0;

	// Saturates so a long excursion cannot wrap back under the filter length
	assign next_over_cnt = !over ? 5'h0 : (&over_cnt ? over_cnt : over_cnt + 5'h1);
	always_ff @(posedge i_clk) begin
		over_cnt <= !i_rst_n ? 5'h0 : next_over_cnt;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_at_zero;
		// The reported value lags a cycle, so the first ramp cycle shows a stale value
		o_ramp_active && $past(o_ramp_active) && o_ramp_mv == 16'h0 ##2 o_ramp_active;
	endsequence
	sequence s_ov_entry;
		$rose(o_overvoltage_fault) && $past(o_output_good);
	endsequence

	a_phase_no_clash: assert property ((o_phase_hi_en & o_phase_lo_en) == '0)
		else $error("phase driven high and low");
	a_ov_lows_on: assert property (o_overvoltage_fault && !o_ramp_active |->
		&o_phase_lo_en && o_phase_hi_en == '0)
		else $error("overvoltage phases not low");
	a_ramp_hi_off: assert property (o_ramp_active |-> o_phase_hi_en == '0 && !o_output_good)
		else $error("high side on during ramp");
	a_ramp_step: assert property (o_ramp_active && $past(o_ramp_active, 2) && $past(o_ramp_active)
		&& $changed(o_ramp_mv) |-> o_ramp_mv == $past(o_ramp_mv) - 16'h1)
		else $error("ramp step not one");
	a_hold_lows: assert property (s_at_zero |-> &o_phase_lo_en)
		else $error("lows not held at zero");
	a_uv_float: assert property ($rose(o_undervoltage_fault) |-> flt && !o_output_good)
		else $error("undervoltage not floated");
	a_off_float: assert property ((!i_enable)[*4] |-> flt && !o_output_good)
		else $error("disabled phases not floated");
	a_ov_filter: assert property (s_ov_entry |-> $past(over_cnt) >= 5'd20 && !o_output_good)
		else $error("overvoltage trip too early");
	a_read_answer: assert property (i_cmd_valid |=> o_rd_valid && o_rd_data[15:8] == 8'h0)
		else $error("read answer missing");
	a_good_excl: assert property (o_output_good |-> !o_soft_start_run && !o_overvoltage_fault)
		else $error("good outside run");
endmodule : buck_prot_sva

bind buck_fault_protection_telemetry buck_prot_sva #(
	.PHASES(PHASES),
	.OV_MARGIN_MV(OV_MARGIN_MV)
) buck_prot_sva_inst (
	.i_clk, .i_rst_n, .i_enable, .i_sense_mv, .i_ref_mv, .i_cmd_valid, .o_phase_hi_en,
	.o_phase_lo_en, .o_output_good, .o_soft_start_run, .o_overvoltage_fault,
	.o_undervoltage_fault, .o_ramp_active, .o_ramp_mv, .o_rd_data, .o_rd_valid
);

// ==== tb/test_buck_fault_protection_telemetry.sv ====
`timescale 1ns/100ps

module test_buck_fault_protection_telemetry;
	logic        i_clk   = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        en = 1'b0, sok = 1'b0, ssd = 1'b0, cv = 1'b0, mv = 1'b0, oth = 1'b0;
	logic [2:0]  strap = 3'h0;
	logic [9:0]  cs = 10'h0, ms = 10'h0;
	logic [15:0] sense = 16'h0, ref_mv = 16'h0, seed = 16'h003c, rnd, exp_c, rd, rmv;
	logic [7:0]  code = 8'h0;
	logic [5:0]  pwm = 6'h0, hi, lo, mid, lvl;
	logic        good, ss, ovf, uvf, ra, rv;
	int          n_fail  = 0;
	int          n_tests = 0;

	always #25 i_clk = ~i_clk;

	buck_fault_protection_telemetry #(
		.GOOD_DELAY_CYC(20),
		.HICCUP_CYC(50)
	) buck_fault_protection_telemetry_inst (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_enable(en), .i_supply_ok(sok),
		.i_strap_code(strap), .i_ceiling_sample(cs), .i_monitor_sample(ms),
		.i_monitor_valid(mv), .i_sense_mv(sense), .i_ref_mv(ref_mv), .i_soft_start_done(ssd),
		.i_other_fault(oth), .i_pwm_req(pwm), .i_cmd_valid(cv), .i_cmd_code(code),
		.o_phase_hi_en(hi), .o_phase_lo_en(lo), .o_output_good(good), .o_soft_start_run(ss),
		.o_overvoltage_fault(ovf), .o_undervoltage_fault(uvf), .o_ramp_active(ra),
		.o_ramp_mv(rmv), .o_rd_data(rd), .o_rd_valid(rv)
	);

	phase_receiver_model phase_receiver_model_inst (
		.i_hi_en(hi), .i_lo_en(lo), .o_mid(mid), .o_level(lvl)
	);

	function automatic logic [15:0] xs();
		seed = seed ^ (seed << 7);
		seed = seed ^ (seed >> 9);
		seed = seed ^ (seed << 8);
		return seed;
	endfunction : xs

	// Ten-bit conversion to amps; saturation guards wider converters
	function automatic logic [15:0] code_of(input logic [9:0] s);
		return (s >> 2) > 10'd255 ? 16'h00ff : {8'h0, s[9:2]};
	endfunction : code_of

	function automatic logic fl(input int k);
		case (k)
			0: return good === 1'b1;
			1: return ovf === 1'b1;
			2: return uvf === 1'b1;
			3: return ss === 1'b1;
			default: return ra === 1'b1 && rmv === 16'h0;
		endcase
	endfunction : fl

	task automatic report_and_stop();
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc

	task automatic wfl(input int k, input int lim);
		for (int i = 0; i <= lim; i++) begin
			@(negedge i_clk);
			if (fl(k))
				return;
		end
		n_fail++;
		$display("BAD wait %0d exp 1 seen 0", k);
		report_and_stop();
	endtask : wfl

	task automatic rdc(input logic [7:0] c, input logic [15:0] e);
		@(posedge i_clk);
		cv <= 1'b1;
		code <= c;
		@(posedge i_clk);
		cv <= 1'b0;
		@(negedge i_clk);
		chk("rd_valid", 16'(rv), 16'h1);
		chk("rd_data", rd, e);
	endtask : rdc

	task automatic start(input logic [2:0] st, input logic [15:0] r);
		@(posedge i_clk);
		en <= 1'b0;
		ssd <= 1'b0;
		cyc(4);
		rnd = xs();
		strap <= st;
		ref_mv <= r;
		sense <= r;
		sok <= 1'b1;
		cs <= rnd[9:0];
		en <= 1'b1;
		wfl(3, 10);
		@(posedge i_clk);
		// Above reference plus margin, still under the fixed start-up ceiling
		sense <= 16'd2000;
		cyc(30);
		@(negedge i_clk);
		chk("ss_ov", 16'(ovf), 16'h0);
		@(posedge i_clk);
		sense <= r;
		ssd <= 1'b1;
		wfl(0, 200);
		rdc(8'hdd, code_of(cs));
	endtask : start

	initial begin
		cyc(6);
		i_rst_n <= 1'b1;
		start(3'h0, 16'd1000);
		exp_c = code_of(cs);
		@(posedge i_clk);
		cs <= ~cs;
		rdc(8'hdd, exp_c);
		for (int i = 0; i < 6; i++) begin
			rnd = xs();
			@(posedge i_clk);
			ms <= (i == 0) ? 10'h3ff : ((i == 1) ? 10'd1020 : rnd[9:0]);
			pwm <= rnd[15:10];
			mv <= 1'b1;
			@(posedge i_clk);
			mv <= 1'b0;
			rdc(8'h8c, code_of(ms));
			rdc(rnd[7:0] & 8'h7e, 16'h0);
			chk("level", 16'(lvl), 16'(pwm));
			chk("mid", 16'(mid), 16'h0);
		end
		@(posedge i_clk);
		sense <= 16'd1201;
		cyc(20);
		sense <= 16'd1000;
		cyc(3);
		@(negedge i_clk);
		chk("ov_short", 16'(ovf), 16'h0);
		@(posedge i_clk);
		sense <= 16'd1201;
		wfl(1, 30);
		chk("ov_good", 16'(good), 16'h0);
		chk("ov_lo", 16'(lo), 16'h003f);
		@(posedge i_clk);
		sense <= 16'd1175;
		cyc(10);
		@(negedge i_clk);
		chk("ov_hyst", 16'(ovf), 16'h1);
		@(posedge i_clk);
		sense <= 16'd1174;
		wfl(0, 10);
		@(posedge i_clk);
		sense <= 16'd699;
		cyc(100);
		sense <= 16'd1000;
		cyc(2);
		@(negedge i_clk);
		chk("uv_short", 16'(uvf), 16'h0);
		@(posedge i_clk);
		sense <= 16'd699;
		wfl(2, 120);
		chk("uv_mid", 16'(mid), 16'h003f);
		chk("uv_good", 16'(good), 16'h0);
		@(posedge i_clk);
		sense <= 16'd1000;
		cyc(40);
		@(negedge i_clk);
		chk("hiccup_idle", 16'(ss), 16'h0);
		wfl(3, 30);
		wfl(0, 300);
		// Another protection forces a hiccup; overvoltage must stay disarmed in its idle time
		@(posedge i_clk);
		oth <= 1'b1;
		sense <= 16'd1500;
		cyc(30);
		@(negedge i_clk);
		chk("hic_ov", 16'(ovf), 16'h0);
		chk("hic_mid", 16'(mid), 16'h003f);
		@(posedge i_clk);
		oth <= 1'b0;
		sense <= 16'd1000;
		wfl(0, 300);
		start(3'h2, 16'd100);
		@(posedge i_clk);
		sense <= 16'd1000;
		wfl(1, 30);
		cyc(3);
		@(negedge i_clk);
		chk("ramp", 16'(ra), 16'h1);
		chk("ramp_lo_on", 16'(lo), 16'h003f);
		@(posedge i_clk);
		sense <= 16'h0;
		cyc(3);
		@(negedge i_clk);
		chk("ramp_lo_off", 16'(lo), 16'h0);
		wfl(4, 5000);
		cyc(3);
		@(negedge i_clk);
		chk("hold_lo", 16'(lo), 16'h003f);
		chk("hold_good", 16'(good), 16'h0);
		start(3'h1, 16'd1000);
		@(posedge i_clk);
		sense <= 16'd500;
		wfl(2, 120);
		@(posedge i_clk);
		sense <= 16'd1000;
		cyc(200);
		@(negedge i_clk);
		chk("latch_ss", 16'(ss), 16'h0);
		chk("latch_mid", 16'(mid), 16'h003f);
		@(posedge i_clk);
		sok <= 1'b0;
		cyc(4);
		@(negedge i_clk);
		chk("uv_clear", 16'(uvf), 16'h0);
		for (int st = 4; st < 8; st++) begin
			start(3'(st), 16'd1000);
			@(posedge i_clk);
			sense <= 16'd1500;
			cyc(50);
			sense <= 16'd0;
			cyc(150);
			@(negedge i_clk);
			chk("off_ov", 16'(ovf), 16'h0);
			chk("off_uv", 16'(uvf), 16'h0);
			chk("off_good", 16'(good), 16'h1);
		end
		report_and_stop();
	end
endmodule : test_buck_fault_protection_telemetry
